// file: irq_subst_consts.svh
`ifndef IRQ_SUBST_CONSTS_SVH
`define IRQ_SUBST_CONSTS_SVH

// ==========================================================
// Register addressing
`define INDEX_SEL_PARALLEL_ROUTE 3'h4
`define INDEX_SEL_REVISION       3'h6
`define HOST_ADDR_INDEXED        3'h7

// ==========================================================
// Field positions and reset values
`define ROUTE_FIELD_MSB          3
`define PARALLEL_ROUTE_RESET     8'h00

// ==========================================================
// Routing codes
`define ROUTE_DISABLED           4'h0
`define ROUTE_STAND_ALONE        4'hF

`endif

// file: irq_subst_pkg.sv
`default_nettype none
package irq_subst_pkg;
  // Mux inputs that a substitution can replace
  typedef enum {
    SLOT_NONE,
    SLOT_IRQ3,
    SLOT_IRQ4,
    SLOT_IRQ5,
    SLOT_IRQ6,
    SLOT_IRQ7,
    SLOT_IRQ10,
    SLOT_IRQ11,
    SLOT_ROM_WIDTH,
    SLOT_IRQ15
  } route_slot_t;
endpackage
`default_nettype wire

// file: irq_route_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_subst_consts.svh"

module irq_route_decode
  import irq_subst_pkg::*;
(
  input  wire logic [3:0] i_code,
  input  wire logic       i_enable,
  output route_slot_t     o_slot
);

  // ==========================================================
  // Routing code decode
  always_comb begin
    o_slot = SLOT_NONE;
    if (i_enable) begin
      unique case (i_code)
        4'h1:    o_slot = SLOT_IRQ3;
        4'h2:    o_slot = SLOT_IRQ4;
        4'h3:    o_slot = SLOT_IRQ5;
        4'h4:    o_slot = SLOT_IRQ6;
        4'h5:    o_slot = SLOT_IRQ7;
        4'h6:    o_slot = SLOT_IRQ10;
        4'h7:    o_slot = SLOT_IRQ11;
        4'h8:    o_slot = SLOT_ROM_WIDTH;
        4'h9:    o_slot = SLOT_IRQ15;
        default: o_slot = SLOT_NONE;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: irq_source_substitution.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_subst_consts.svh"

module irq_source_substitution
  import irq_subst_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h01  // Arbitrary value
)
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic [2:0] i_index_sel,
  input  wire logic [2:0] i_host_addr,
  input  wire logic       i_wr_stb,
  input  wire logic       i_rd_stb,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_parallel_irq_output_enable,
  input  wire logic       i_serial0_enable,
  input  wire logic       i_serial1_enable,
  input  wire logic [3:0] i_serial0_irq_route_field,
  input  wire logic [3:0] i_serial1_irq_route_field,
  input  wire logic       i_parallel_irq,
  input  wire logic       i_serial0_irq,
  input  wire logic       i_serial1_irq,
  input  wire logic [7:0] i_irq_group_a,
  input  wire logic [7:0] i_irq_group_b,
  input  wire logic [2:0] i_mux_phase_select,
  output logic      [7:0] o_rd_data,
  output logic            o_muxed_irq_out_a,
  output logic            o_muxed_irq_out_b,
  output logic            o_stand_alone
);

  // ==========================================================
  // Register decode
  logic hit_route;
  logic hit_rev;

  // Both registers share host address 7; the index picks one
  function automatic logic index_hit(input logic [2:0] idx);
    return (i_index_sel == idx) && (i_host_addr == `HOST_ADDR_INDEXED);
  endfunction

  assign hit_route = index_hit(`INDEX_SEL_PARALLEL_ROUTE);
  assign hit_rev   = index_hit(`INDEX_SEL_REVISION);

  // ==========================================================
  // Routing register
  logic [7:0] parallel_irq_route;
  logic [7:0] next_parallel_irq_route;

  always_comb begin
    next_parallel_irq_route = parallel_irq_route;
    // Upper bits are stored as written; software keeps them zero
    if (i_wr_stb && hit_route) begin
      next_parallel_irq_route = i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      parallel_irq_route <= `PARALLEL_ROUTE_RESET;
    end else begin
      parallel_irq_route <= next_parallel_irq_route;
    end
  end

  // ==========================================================
  // Read data
  logic [7:0] next_rd_data;

  always_comb begin
    // Idle cycles and unmapped reads give zero
    next_rd_data = 8'h00;
    if (i_rd_stb && hit_route) begin
      next_rd_data = parallel_irq_route;
    end else if (i_rd_stb && hit_rev) begin
      next_rd_data = ~SILICON_REV;  // Writes never reach this
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // ==========================================================
  // Route decode
  route_slot_t pp_slot;
  route_slot_t s0_slot;
  route_slot_t s1_slot;
  logic        stand_alone;

  irq_route_decode u_pp_dec (
    .i_code   (parallel_irq_route[`ROUTE_FIELD_MSB:0]),
    .i_enable (i_parallel_irq_output_enable),
    .o_slot   (pp_slot)
  );
  irq_route_decode u_s0_dec (
    .i_code   (i_serial0_irq_route_field),
    .i_enable (i_serial0_enable),
    .o_slot   (s0_slot)
  );
  irq_route_decode u_s1_dec (
    .i_code   (i_serial1_irq_route_field),
    .i_enable (i_serial1_enable),
    .o_slot   (s1_slot)
  );

  assign stand_alone =
    (i_serial0_irq_route_field == `ROUTE_STAND_ALONE);

  // Parallel first, then serial 1, then serial 0; sources never ORed
  function automatic logic subst(input route_slot_t slot,
                                 input logic raw);
    logic v;
    v = raw;
    // A disabled or reserved code decodes to no slot and claims nothing
    if (slot != SLOT_NONE) begin
      if (s0_slot == slot) begin
        v = i_serial0_irq;
      end
      if (s1_slot == slot) begin
        v = i_serial1_irq;
      end
      if (pp_slot == slot) begin
        v = i_parallel_irq;
      end
    end
    return v;
  endfunction

  // ==========================================================
  // Phase lanes
  // Lane A order: IRQ8,9,10,11,ROM line,RESCPU,14,15
  function automatic route_slot_t lane_a_slot(input logic [2:0] phase);
    route_slot_t s;
    unique case (phase)
      3'h0: s = SLOT_NONE;
      3'h1: s = SLOT_NONE;
      3'h2: s = SLOT_IRQ10;
      3'h3: s = SLOT_IRQ11;
      3'h4: s = SLOT_ROM_WIDTH;
      3'h5: s = SLOT_NONE;
      3'h6: s = SLOT_NONE;
      3'h7: s = SLOT_IRQ15;
    endcase
    return s;
  endfunction

  // Lane B order: IRQ12,KBINT,A20GT,IRQ3,4,5,6,7
  function automatic route_slot_t lane_b_slot(input logic [2:0] phase);
    route_slot_t s;
    unique case (phase)
      3'h0: s = SLOT_NONE;
      3'h1: s = SLOT_NONE;
      3'h2: s = SLOT_NONE;
      3'h3: s = SLOT_IRQ3;
      3'h4: s = SLOT_IRQ4;
      3'h5: s = SLOT_IRQ5;
      3'h6: s = SLOT_IRQ6;
      3'h7: s = SLOT_IRQ7;
    endcase
    return s;
  endfunction

  // ==========================================================
  // Phase multiplexing
  // Registered outputs add one cycle of latency behind the phase code
  route_slot_t lane_a;
  route_slot_t lane_b;
  logic        next_out_a;
  logic        next_out_b;

  always_comb begin
    lane_a = lane_a_slot(i_mux_phase_select);
    lane_b = lane_b_slot(i_mux_phase_select);
    if (stand_alone) begin
      // Parallel interrupt has no pin of its own here in stand-alone
      next_out_a = i_serial0_irq;
      next_out_b = i_serial1_irq;
    end else begin
      next_out_a = subst(lane_a, i_irq_group_a[i_mux_phase_select]);
      next_out_b = subst(lane_b, i_irq_group_b[i_mux_phase_select]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_muxed_irq_out_a <= 1'b0;
      o_muxed_irq_out_b <= 1'b0;
      o_stand_alone     <= 1'b0;
    end else begin
      o_muxed_irq_out_a <= next_out_a;
      o_muxed_irq_out_b <= next_out_b;
      o_stand_alone     <= stand_alone;
    end
  end

endmodule

`default_nettype wire

// file: irq_subst_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module irq_subst_asserts #(parameter logic [7:0] SILICON_REV = 8'h01) (
  input wire logic i_sys_clk, i_nrst, i_wr_stb, i_rd_stb, o_stand_alone,
  input wire logic [2:0] i_index_sel, i_host_addr, i_mux_phase_select,
  input wire logic [7:0] i_wr_data, i_irq_group_a, i_irq_group_b, o_rd_data,
  input wire logic [3:0] i_serial0_irq_route_field, i_serial1_irq_route_field,
  input wire logic i_parallel_irq_output_enable, i_serial1_enable,
  input wire logic i_parallel_irq, i_serial0_irq, i_serial1_irq,
  input wire logic o_muxed_irq_out_a, o_muxed_irq_out_b
);
  wire logic [3:0] s0 = i_serial0_irq_route_field;
  wire logic [3:0] s1 = i_serial1_irq_route_field;
  wire logic [2:0] ph = i_mux_phase_select;
  wire logic at7 = i_host_addr == 3'h7;
  logic [7:0] route;
  wire logic [3:0] pr = route[3:0];
  // ======
  // Shadow of the routing register, seen only through the host writes
  always_ff @(posedge i_sys_clk)
    if (!i_nrst) route <= 8'h00;
    else if (i_wr_stb && at7 && i_index_sel == 3'h4) route <= i_wr_data;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_rev_read: assert property (
    i_rd_stb && at7 && i_index_sel == 3'h6 |=> o_rd_data == ~SILICON_REV)
    else $error("bad version read");
  a_route_read: assert property (
    i_rd_stb && at7 && i_index_sel == 3'h4 |=> o_rd_data == $past(route))
    else $error("bad route read");
  a_unmapped_zero: assert property (
    i_rd_stb && !(at7 && i_index_sel inside {3'h4, 3'h6}) |=> o_rd_data == 0)
    else $error("unmapped read not zero");
  a_stand_flag: assert property (s0 == 4'hF |=> o_stand_alone)
    else $error("stand-alone flag low");
  a_stand_out: assert property (
    s0 == 4'hF |=> o_muxed_irq_out_a == $past(i_serial0_irq))
    else $error("stand-alone output wrong");
  a_plain_pass: assert property (
    s0 == 0 && s1 == 0 && pr == 0
    |=> o_muxed_irq_out_a == $past(i_irq_group_a[ph]))
    else $error("phase select wrong");
  a_par_gated: assert property (
    !i_parallel_irq_output_enable && s0 == 0 && s1 == 0 && ph == 3'h3
    |=> o_muxed_irq_out_b == $past(i_irq_group_b[3]))
    else $error("disabled parallel substituted");
  a_par_wins: assert property (
    i_parallel_irq_output_enable && pr == 1 && s1 == 1 && s0 != 4'hF &&
    ph == 3'h3 |=> o_muxed_irq_out_b == $past(i_parallel_irq))
    else $error("parallel lost priority");
  a_s1_wins: assert property (
    i_serial1_enable && pr == 0 && s0 == 1 && s1 == 1 && ph == 3'h3
    |=> o_muxed_irq_out_b == $past(i_serial1_irq))
    else $error("serial 1 lost priority");
endmodule
bind irq_source_substitution irq_subst_asserts
  #(.SILICON_REV(SILICON_REV)) i_irq_subst_asserts (.*);
`default_nettype wire

// file: irq_phase_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module irq_phase_ctl (
  input  wire logic [2:0] i_phase,
  output logic      [2:0] o_mux_phase_select
);
  assign o_mux_phase_select = i_phase;
endmodule
`default_nettype wire

// file: irq_source_substitution_bench.sv
`timescale 1ns/10ps
`default_nettype none
module irq_source_substitution_bench;
  localparam logic [7:0] REV = 8'h5A;  // Arbitrary value
  // Output pair {a,b} and phase per routing code; code 10 is reserved
  localparam logic [4:0] TBL [11] = '{5'h03, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h14, 5'h17, 5'h03};
  // Mixed patterns so a wrong phase shows on either output, except the mirrored phase 7-p
  localparam logic [7:0] GA = 8'hA5;
  localparam logic [7:0] GB = 8'h3C;
  logic i_sys_clk = 0, i_nrst = 0, i_wr_stb = 0, i_rd_stb = 0;
  logic i_parallel_irq_output_enable = 0, i_serial0_enable = 0;
  logic i_serial1_enable = 0, i_parallel_irq = 0;
  logic i_serial0_irq = 0, i_serial1_irq = 0, o_stand_alone;
  logic [2:0] i_index_sel = 0, i_host_addr = 0, ph = 0, i_mux_phase_select;
  logic [7:0] i_wr_data = 0, i_irq_group_a = 0, i_irq_group_b = 0, o_rd_data;
  logic [3:0] i_serial0_irq_route_field = 0, i_serial1_irq_route_field = 0;
  logic o_muxed_irq_out_a, o_muxed_irq_out_b;
  int n_errors = 0, cmp_count = 0;
  irq_source_substitution #(.SILICON_REV(REV)) i_irq_source_substitution (.*);
  irq_phase_ctl i_irq_phase_ctl (
    .i_phase           (ph),
    .o_mux_phase_select(i_mux_phase_select)
  );
  initial forever #50 i_sys_clk = ~i_sys_clk;
  // ======
  // Tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(negedge i_sys_clk);
  endtask
  // Read data stands one cycle, so it is compared before the idle cycle
  task automatic acc(input logic w, input logic [2:0] idx, input logic [7:0] d);
    {i_wr_stb, i_rd_stb} = {w, !w};
    {i_index_sel, i_host_addr, i_wr_data} = {idx, 3'h7, d};
    tick;
    if (!w) cmp(o_rd_data, d);
    {i_wr_stb, i_rd_stb} = 2'b00;
    tick;
  endtask
  task automatic chk(input logic [1:0] e);
    tick;
    cmp({6'h00, o_muxed_irq_out_a, o_muxed_irq_out_b}, {6'h00, e});
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    wrap_up;
  end
  // ======
  // Main sequence
  initial begin
    repeat (3) tick;
    i_nrst = 1;
    acc(0, 3'h4, 8'h00);
    acc(0, 3'h6, ~REV);
    acc(1, 3'h6, 8'h33);
    acc(0, 3'h6, ~REV);
    acc(0, 3'h5, 8'h00);
    acc(1, 3'h4, 8'h09);
    acc(0, 3'h4, 8'h09);
    i_nrst = 0;
    tick;
    i_nrst = 1;
    acc(0, 3'h4, 8'h00);
    $display("registers done");
    {i_irq_group_a, i_irq_group_b} = {GA, GB};
    for (int p = 0; p < 8; p++) begin
      ph = 3'(p);
      chk({GA[p], GB[p]});
    end
    {i_irq_group_a, i_irq_group_b} = 16'h0000;
    $display("phase done");
    {i_parallel_irq_output_enable, i_parallel_irq} = 2'b11;
    foreach (TBL[c]) begin
      acc(1, 3'h4, 8'(c));
      ph = TBL[c][2:0];
      chk(TBL[c][4:3]);
    end
    acc(1, 3'h4, 8'h01);
    i_parallel_irq_output_enable = 0;
    chk(2'b00);
    {i_parallel_irq_output_enable, i_parallel_irq, i_serial1_irq} = 3'b101;
    {i_serial0_enable, i_serial1_enable} = 2'b11;
    {i_serial0_irq_route_field, i_serial1_irq_route_field} = 8'h11;
    chk(2'b00);
    acc(1, 3'h4, 8'h00);
    {i_serial0_irq, i_serial1_irq} = 2'b10;
    chk(2'b00);
    $display("routing done");
    i_serial0_irq_route_field = 4'hF;
    chk(2'b10);
    cmp({7'h00, o_stand_alone}, 8'h01);
    $display("stand-alone done");
    wrap_up;
  end
endmodule
`default_nettype wire
